/* File: cfg_access_cfg.svh */
// constants for the configuration register access endpoint
`ifndef CFG_ACCESS_CFG_SVH
`define CFG_ACCESS_CFG_SVH
`define TOK_WRITE     8'hc0
`define TOK_READ      8'hc1
`define TOK_END       8'h01
`define TOK_ACK       8'h03
`define TOK_NACK      8'h04
`define NO_REPLY_LOW  8'hff
`define REG_COUNT     16'h0010
`define REG_ADDR_W    4
`define REG_RESET     32'h0000_0000
`define PS_SHIFT      8
`define PS_TYPE       32'h0000_000b
`define TILE_CFG_LOW  16'hc20c
`define NODE_CFG_LOW  16'hc30c
`endif

/* File: cfg_access_pkg.sv */
// types for the configuration register access endpoint
package cfg_access_pkg;
  typedef enum logic [3:0] {
    st_idle  = 4'b0000,
    st_chan  = 4'b0001,
    st_regn  = 4'b0010,
    st_data  = 4'b0011,
    st_term  = 4'b0100,
    st_exec  = 4'b0101,
    st_rdw   = 4'b0110,
    st_head  = 4'b0111,
    st_rdat  = 4'b1000,
    st_tail  = 4'b1001,
    st_skip  = 4'b1010
  } state_t;
endpackage

/* File: cfg_reg_mem.sv */
// small register bank memory with registered read data
`timescale 1ns/1ps
`include "cfg_access_cfg.svh"
module cfg_reg_mem (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   we,
  input  wire logic [`REG_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  output logic      [31:0]            rdata
);
  logic [31:0] mem [0:(1<<`REG_ADDR_W)-1];

  genvar i;
  generate
    for (i = 0; i < (1<<`REG_ADDR_W); i++) begin : g_word
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mem[i] <= `REG_RESET;
        end else if (we && addr == i[`REG_ADDR_W-1:0]) begin
          mem[i] <= wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= `REG_RESET;
    end else begin
      rdata <= mem[addr];
    end
  end
endmodule

/* File: cfg_access.sv */
// configuration endpoint: decodes framed read/write messages, replies
// Behaviour
// - reply field low byte all ones on successful write: no reply sent
// - multi-byte fields travel most significant byte first
// - write: token 192, 24b reply, 16b register, 32b data, token 1
// - read: token 193, 24b reply, 16b register, token 1
// - write reply: tokens 3,1 on success; tokens 4,1 on failure
// - read reply: token 3, 32b value, token 1; else tokens 4,1
// - status register id is register number shifted 8, ORed with 0x0b
`timescale 1ns/1ps
`include "cfg_access_cfg.svh"
module cfg_access
  import cfg_access_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        rx_valid,
  input  wire logic        rx_ctrl,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  output logic             tx_valid,
  output logic             tx_ctrl,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  output logic [23:0]      reply_dest,
  input  wire logic [15:0] ps_reg_num,
  output logic [31:0]      ps_res_id
);
  typedef struct packed {
    state_t      st;
    logic        is_wr;
    logic        bad;
    logic [1:0]  cnt;
    logic [23:0] chan;
    logic [15:0] regn;
    logic [31:0] data;
    logic        ok;
    logic        tv;
    logic        tc;
    logic [7:0]  td;
    logic [31:0] rid;
  } ctx_t;

  ctx_t        cur;
  ctx_t        next_cur;
  logic        mem_we;
  logic [31:0] mem_rdata;
  logic        take;
  logic        sent;
  logic        is_term;
  logic        quiet;

  // read data come one cycle after the address, hence the st_rdw wait
  cfg_reg_mem u_mem (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (mem_we),
    .addr  (cur.regn[`REG_ADDR_W-1:0]),
    .wdata (cur.data),
    .rdata (mem_rdata)
  );

  // input is accepted only while parsing, so replies never overlap requests
  assign rx_ready = (cur.st == st_idle) || (cur.st == st_chan) ||
                    (cur.st == st_regn) || (cur.st == st_data) ||
                    (cur.st == st_term) || (cur.st == st_skip);
  assign take     = rx_valid && rx_ready;
  assign sent     = cur.tv && tx_ready;
  assign is_term  = rx_ctrl && rx_data == `TOK_END;
  // failures are always answered, even when the reply field asks for none
  assign quiet    = cur.is_wr && cur.ok && cur.chan[7:0] == `NO_REPLY_LOW;
  assign mem_we   = (cur.st == st_exec) && cur.is_wr && cur.ok;
  assign tx_valid = cur.tv;
  assign tx_ctrl  = cur.tc;
  assign tx_data  = cur.td;
  assign reply_dest = cur.chan;
  assign ps_res_id  = cur.rid;

  always_comb begin
    next_cur = cur;
    // registered so the id comes straight from a flop, one cycle late
    next_cur.rid = ({16'h0000, ps_reg_num} << `PS_SHIFT) | `PS_TYPE;
    case (cur.st)
      st_idle: begin
        if (take) begin
          next_cur.cnt = 2'd0;
          next_cur.bad = 1'b0;
          next_cur.is_wr = (rx_data == `TOK_WRITE);
          if (rx_ctrl && (rx_data == `TOK_WRITE ||
                          rx_data == `TOK_READ)) begin
            next_cur.st = st_chan;
          end else if (!is_term) begin
            next_cur.st = st_skip;
          end
        end
      end
      st_chan: begin
        if (take) begin
          next_cur.chan = {cur.chan[15:0], rx_data};
          if (rx_ctrl) begin
            next_cur.bad = 1'b1;
          end
          if (cur.cnt == 2'd2) begin
            next_cur.cnt = 2'd0;
            next_cur.st = st_regn;
          end else begin
            next_cur.cnt = cur.cnt + 2'd1;
          end
        end
      end
      st_regn: begin
        if (take) begin
          next_cur.regn = {cur.regn[7:0], rx_data};
          if (rx_ctrl) begin
            next_cur.bad = 1'b1;
          end
          if (cur.cnt == 2'd1) begin
            next_cur.cnt = 2'd0;
            next_cur.st = cur.is_wr ? st_data : st_term;
          end else begin
            next_cur.cnt = cur.cnt + 2'd1;
          end
        end
      end
      st_data: begin
        if (take) begin
          next_cur.data = {cur.data[23:0], rx_data};
          if (rx_ctrl) begin
            next_cur.bad = 1'b1;
          end
          next_cur.cnt = cur.cnt + 2'd1;
          if (cur.cnt == 2'd3) begin
            next_cur.st = st_term;
          end
        end
      end
      st_term: begin
        if (take) begin
          // a wrong terminator still closes the frame, answered as failure
          next_cur.ok = !cur.bad && is_term &&
                        cur.regn < `REG_COUNT;
          next_cur.st = st_exec;
        end
      end
      st_exec: begin
        if (quiet) begin
          next_cur.st = st_idle;
        end else if (!cur.is_wr && cur.ok) begin
          next_cur.st = st_rdw;
        end else begin
          next_cur.st = st_head;
        end
      end
      st_rdw: begin
        next_cur.data = mem_rdata;
        next_cur.st = st_head;
      end
      st_head: begin
        // first cycle loads the token, so tx_* leave flops, not this logic
        if (!cur.tv) begin
          next_cur.tv = 1'b1;
          next_cur.tc = 1'b1;
          next_cur.td = cur.ok ? `TOK_ACK : `TOK_NACK;
          next_cur.cnt = 2'd0;
        end else if (sent) begin
          if (cur.ok && !cur.is_wr) begin
            next_cur.st = st_rdat;
            next_cur.tc = 1'b0;
            next_cur.td = cur.data[31:24];
          end else begin
            next_cur.st = st_tail;
            next_cur.td = `TOK_END;
          end
        end
      end
      st_rdat: begin
        if (sent) begin
          next_cur.data = {cur.data[23:0], 8'h00};
          next_cur.cnt = cur.cnt + 2'd1;
          if (cur.cnt == 2'd3) begin
            next_cur.st = st_tail;
            next_cur.tc = 1'b1;
            next_cur.td = `TOK_END;
          end else begin
            next_cur.td = cur.data[23:16];
          end
        end
      end
      st_tail: begin
        if (sent) begin
          next_cur.tv = 1'b0;
          next_cur.tc = 1'b0;
          next_cur.td = 8'h00;
          next_cur.st = st_idle;
        end
      end
      st_skip: begin
        // resynchronise: discard until a terminator, then answer failure
        if (take && is_term) begin
          next_cur.ok = 1'b0;
          next_cur.is_wr = 1'b0;
          next_cur.st = st_head;
        end
      end
      default: begin
        next_cur.st = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule

/* File: cfg_access_assertions.sv */
// port assertions for the configuration endpoint
`timescale 1ns/1ps
module cfg_access_assertions (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        rx_ready,
  input wire logic        tx_valid,
  input wire logic        tx_ctrl,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_ready,
  input wire logic [23:0] reply_dest,
  input wire logic [15:0] ps_reg_num,
  input wire logic [31:0] ps_res_id
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic fire = tx_valid && tx_ready;
  wire logic ctl1 = tx_ctrl && tx_data == 8'h01;
  chk_res_id: assert property (
    $past(rst_n) |-> ps_res_id == {8'h00, $past(ps_reg_num), 8'h0b})
    else $error("bad res id");
  chk_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable({tx_ctrl, tx_data}))
    else $error("reply token not held");
  chk_rx_block: assert property (
    tx_valid |-> !rx_ready) else $error("request taken during reply");
  chk_tok_legal: assert property (
    tx_valid && tx_ctrl |-> tx_data inside {8'h01, 8'h03, 8'h04})
    else $error("illegal reply token");
  chk_nack_end: assert property (
    fire && tx_ctrl && tx_data == 8'h04 |-> ##[1:4] (tx_valid && ctl1))
    else $error("failure not closed");
  chk_ack_more: assert property (
    fire && tx_ctrl && tx_data == 8'h03 |-> ##[1:4] tx_valid)
    else $error("nothing after ack");
  chk_dest_hold: assert property (
    tx_valid && $past(tx_valid) |-> $stable(reply_dest))
    else $error("reply dest moved");
  chk_end_free: assert property (
    fire && ctl1 |=> !tx_valid ##[0:2] rx_ready)
    else $error("not idle after reply");
  cover property (fire && tx_ctrl && tx_data == 8'h04);
  cover property (fire && !tx_ctrl);
  cover property (tx_valid && !tx_ready);
endmodule

/* File: cfg_requester.sv */
// requesting channel-end model: sinks reply tokens, may stall
`timescale 1ns/1ps
module cfg_requester (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic       tx_ctrl,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [8:0] q[$];
  initial tx_ready = 1'b0;
  // stalling alternates ready so each token after the first of a reply must wait
  always @(negedge clk) tx_ready <= slow ? !tx_ready : 1'b1;
  always @(posedge clk)
    if (tx_valid && tx_ready) q.push_back({tx_ctrl, tx_data});
endmodule

/* File: config_register_access_tb_top.sv */
// testbench for the configuration endpoint
`timescale 1ns/1ps
`include "cfg_access_cfg.svh"
module config_register_access_tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, rx_valid = 1'b0, rx_ctrl = 1'b0;
  logic        slow = 1'b0, rx_ready, tx_valid, tx_ctrl, tx_ready;
  logic [7:0]  rx_data = 8'h00, tx_data;
  logic [15:0] ps_reg_num = 16'h0000;
  logic [23:0] reply_dest;
  logic [31:0] ps_res_id;
  logic [31:0] dest = 32'h0000_0000;
  logic [8:0]  exp_q[$];
  int          error_cnt = 0, tests_run = 0, cycles = 0;
  initial forever #20 clk = ~clk;
  cfg_access i_cfg_access (.clk, .rst_n, .rx_valid, .rx_ctrl, .rx_data,
    .rx_ready, .tx_valid, .tx_ctrl, .tx_data, .tx_ready, .reply_dest,
    .ps_reg_num, .ps_res_id);
  cfg_requester i_cfg_requester (.clk, .slow, .tx_valid, .tx_ctrl, .tx_data,
    .tx_ready);
  task automatic print_verdict;
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tok(logic c, logic [7:0] d);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_ctrl = c;
    rx_data = d;
    while (!rx_ready) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic msg(logic [7:0] op, logic [23:0] ch, logic [15:0] rn,
                     logic [31:0] d, logic [7:0] term);
    logic hit;
    hit = dest[15:0] == `TILE_CFG_LOW || dest[15:0] == `NODE_CFG_LOW;
    check("dest endpoint", 32'h0000_0001, {31'h0, hit});
    tok(1'b1, op);
    for (int i = 2; i >= 0; i--) tok(1'b0, ch[i*8 +: 8]);
    for (int i = 1; i >= 0; i--) tok(1'b0, rn[i*8 +: 8]);
    if (op == `TOK_WRITE)
      for (int i = 3; i >= 0; i--) tok(1'b0, d[i*8 +: 8]);
    tok(1'b1, term);
    @(negedge clk);
    rx_valid = 1'b0;
  endtask
  // extra cycles after the last expected token catch surplus replies
  task automatic reply(int n);
    int t = 0;
    logic [8:0] exp_tok;
    logic [8:0] got_tok;
    while (i_cfg_requester.q.size() < exp_q.size() && t < 200) begin
      @(posedge clk);
      t++;
    end
    repeat (n) @(posedge clk);
    check("reply count", exp_q.size(), i_cfg_requester.q.size());
    while (exp_q.size() > 0 && i_cfg_requester.q.size() > 0) begin
      exp_tok = exp_q.pop_front();
      got_tok = i_cfg_requester.q.pop_front();
      check("reply token", {23'h0, exp_tok}, {23'h0, got_tok});
    end
    exp_q.delete();
    i_cfg_requester.q.delete();
  endtask
  task automatic s_write_read;
    dest = {16'h0001, `TILE_CFG_LOW};
    slow = 1'b1;
    msg(`TOK_WRITE, 24'h0a0b0c, 16'h0005, 32'h1234_5678, `TOK_END);
    exp_q = '{9'h103, 9'h101};
    reply(4);
    check("reply dest", 32'h000a_0b0c, {8'h00, reply_dest});
    msg(`TOK_READ, 24'h0a0b0d, 16'h0005, 32'h0, `TOK_END);
    exp_q = '{9'h103, 9'h012, 9'h034, 9'h056, 9'h078, 9'h101};
    reply(4);
    slow = 1'b0;
  endtask
  task automatic s_suppress;
    dest = {16'h0002, `NODE_CFG_LOW};
    msg(`TOK_WRITE, 24'h0a0bff, 16'h000f, 32'hcafe_f00d, `TOK_END);
    reply(20);
    msg(`TOK_READ, 24'h0a0b01, 16'h000f, 32'h0, `TOK_END);
    exp_q = '{9'h103, 9'h0ca, 9'h0fe, 9'h0f0, 9'h00d, 9'h101};
    reply(4);
  endtask
  task automatic s_refuse;
    msg(`TOK_WRITE, 24'h0a0b02, 16'h0010, 32'h1, `TOK_END);
    exp_q = '{9'h104, 9'h101};
    reply(4);
    msg(`TOK_WRITE, 24'h0a0b03, 16'h000f, 32'h1, `TOK_ACK);
    exp_q = '{9'h104, 9'h101};
    reply(4);
    msg(`TOK_READ, 24'h0a0b04, 16'h000f, 32'h0, `TOK_END);
    exp_q = '{9'h103, 9'h0ca, 9'h0fe, 9'h0f0, 9'h00d, 9'h101};
    reply(4);
    msg(`TOK_READ, 24'h0a0b05, 16'h0010, 32'h0, `TOK_END);
    exp_q = '{9'h104, 9'h101};
    reply(4);
  endtask
  // stray terminator, unknown leading token, control token inside a field
  task automatic s_garbage;
    tok(1'b1, `TOK_END);
    @(negedge clk);
    rx_valid = 1'b0;
    reply(8);
    tok(1'b0, 8'h33);
    tok(1'b0, 8'h44);
    tok(1'b1, `TOK_END);
    @(negedge clk);
    rx_valid = 1'b0;
    exp_q = '{9'h104, 9'h101};
    reply(4);
    tok(1'b1, `TOK_WRITE);
    tok(1'b0, 8'h0a);
    tok(1'b1, `TOK_ACK);
    tok(1'b0, 8'h01);
    for (int i = 0; i < 2; i++) tok(1'b0, 8'h00);
    for (int i = 0; i < 4; i++) tok(1'b0, 8'h5a);
    tok(1'b1, `TOK_END);
    @(negedge clk);
    rx_valid = 1'b0;
    exp_q = '{9'h104, 9'h101};
    reply(4);
    msg(`TOK_READ, 24'h0a0b06, 16'h0000, 32'h0, `TOK_END);
    exp_q = '{9'h103, 9'h000, 9'h000, 9'h000, 9'h000, 9'h101};
    reply(4);
  endtask
  task automatic s_ps;
    logic [15:0] v[3] = '{16'h0000, 16'h00a5, 16'hffff};
    logic [31:0] e[3] = '{32'h0000_000b, 32'h0000_a50b, 32'h00ff_ff0b};
    foreach (v[i]) begin
      @(negedge clk);
      ps_reg_num = v[i];
      @(negedge clk);
      check("ps res id", e[i], ps_res_id);
    end
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    s_write_read();
    s_suppress();
    s_refuse();
    s_garbage();
    s_ps();
    print_verdict();
  end
endmodule
bind cfg_access cfg_access_assertions i_cfg_access_assertions (.clk, .rst_n,
  .rx_ready, .tx_valid, .tx_ctrl, .tx_data, .tx_ready, .reply_dest,
  .ps_reg_num, .ps_res_id);
